// ==== hw/meas_dev.sv ====
/*
  Device end: measurement serial output. Takes samples from a stream into
  a 12-entry table (three groups of four channels) and serialises them on
  two output lines in I2S framing or on line A in TDM framing, timed by the far bit clock.
  Assumes bit clock, frame sync and config arrive from another domain.
*/
// Operation
// - only I2S or TDM framing on output
// - timed by host bit clock and frame sync
// - frame rate and size follow audio input
// - output framing follows audio input framing
// - voltage estimates only at 48 kHz
// - three groups of four channels each
// - each I2S line carries this device only
// - shared TDM line needs disjoint slots
// - line select 1: ch1/2 A, ch3/4 B
// - line select 2: ch3/4 A, ch1/2 B
// - host sets group enable 0011 off-TDM; here only with line select 1 or 2, other selects pass the written enables
// - TDM select 0: all groups on A
// - bits 3:2 word length ch1/2 or voltage
// - bits 1:0 word length ch3/4 or current
// - host sets offsets to avoid overlap
// - group enable bits: voltage, current, aux
// - group select off-TDM: voltage/current/aux
// - offset counts bit clocks to group MSB
`timescale 1ns/1ps
module meas_dev
  import meas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  meas_link_if.dev         lnk,
  input  wire logic        s_valid,
  output logic             s_ready,
  input  wire logic [31:0] s_data,
  input  wire logic [1:0]  s_group,
  input  wire logic [1:0]  s_chan
);
  typedef struct packed {
    cfg_t             cfg_s1;
    cfg_t             cfg_s2;
    logic [2:0]       bclk_s;
    logic [1:0]       fs_s;
    logic             fs_prev;
    logic             half;
    logic             start;
    logic [10:0]      cnt;
    logic             a_out;
    logic             a_oe_n;
    logic             b_out;
    logic             b_oe_n;
    logic [11:0][31:0] tbl;
  } dev_st_t;

  dev_st_t s_r, s_nxt;
  logic        q_valid;
  logic [35:0] q_data;
  logic        q_pop;

  // samples queue up here; one drained per bit clock, so a fast source stalls
  meas_fifo #(
    .W     (36),
    .DEPTH (8)
  ) meas_fifo_inst (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .in_data   ({s_group, s_chan, s_data}),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  assign q_pop = s_r.bclk_s[1] & ~s_r.bclk_s[2];

  always_comb begin
    logic        rise;
    logic        fall;
    logic        fsv;
    logic [10:0] c;
    logic [10:0] pos;
    logic [2:0]  en;
    logic [1:0]  g;
    logic [1:0]  ch;
    logic [5:0]  wl;
    logic        pr;
    logic        swap;
    logic [3:0]  line;
    logic [1:0]  oe_n;
    logic [1:0]  d;
    logic [3:0]  idx;
    cfg_t        cf;
    rise  = s_r.bclk_s[1] & ~s_r.bclk_s[2];
    fall  = ~s_r.bclk_s[1] & s_r.bclk_s[2];
    fsv   = s_r.fs_s[1];
    c     = s_r.cnt;
    pos   = '0;
    ch    = '0;
    wl    = '0;
    pr    = 1'b0;
    en    = '0;
    idx   = '0;
    oe_n  = 2'h3;
    d     = 2'h0;
    s_nxt = s_r;
    cf    = s_r.cfg_s2;
    g     = cf.chsel;
    line  = cf.fmt[FMT_LINE_LSB +: 4];
    swap  = (line == LINE_A34);

    // double flop every far input before use
    s_nxt.cfg_s1 = lnk.cfg;
    s_nxt.cfg_s2 = s_r.cfg_s1;
    s_nxt.bclk_s = {s_r.bclk_s[1:0], lnk.bclk};
    s_nxt.fs_s   = {s_r.fs_s[0], lnk.frame_sync};

    // group enables; voltage estimates need 48 kHz
    en[0] = cf.tx_sel[GRP_VPRED] & cf.fs48k;
    en[1] = cf.tx_sel[GRP_ISENSE];
    en[2] = cf.tx_sel[GRP_AUX];

    // table update from the queue, one entry per bit clock
    if (q_pop && q_valid && q_data[35:34] != 2'h3) begin
      s_nxt.tbl[q_data[35:32]] = q_data[31:0];
    end

    // frame edge on the rising bit clock: TDM rising sync, I2S either edge
    if (rise) begin
      if (cf.tdm ? (fsv & ~s_r.fs_prev) : (fsv ^ s_r.fs_prev)) begin
        s_nxt.start = 1'b1;
      end
      s_nxt.fs_prev = fsv;
      s_nxt.half    = fsv;
    end

    // new bit on the falling bit clock; no frame length of our own
    if (fall) begin
      if (s_r.start) begin
        c = '0;
      end else if (s_r.cnt != CNT_IDLE) begin
        c = s_r.cnt + 11'h001;
      end
      s_nxt.start = 1'b0;
      s_nxt.cnt   = c;
      if (cf.tdm) begin
        // all enabled groups on line A, 32-bit slots from each offset
        if (line == LINE_TDM_ALL) begin
          for (int k = 0; k < 3; k++) begin
            if (en[k] && c >= {1'b0, cf.off[k]}) begin
              pos = c - {1'b0, cf.off[k]};
              ch  = pos[6:5];
              wl  = (2'(k) == GRP_VPRED) ? word_bits(cf.fmt[FMT_WLA_LSB +: 2])
                                         : word_bits(cf.fmt[FMT_WLB_LSB +: 2]);
              if (pos < TDM_SPAN && {1'b0, pos[4:0]} < wl) begin
                oe_n[0] = 1'b0;
                d[0]    = s_r.tbl[{2'(k), ch}][5'h1f - pos[4:0]];
              end
            end
          end
        end
      end else if ((line == LINE_A12 || line == LINE_A34) && g != 2'h3) begin
        // one selected group, channel pairs split over the two lines
        if (en[g] && c >= {1'b0, cf.off[g]}) begin
          pos = c - {1'b0, cf.off[g]};
          for (int l = 0; l < 2; l++) begin
            pr  = 1'(l) ^ swap;
            wl  = pr ? word_bits(cf.fmt[FMT_WLB_LSB +: 2])
                     : word_bits(cf.fmt[FMT_WLA_LSB +: 2]);
            idx = {g, pr, s_r.half};
            if (pos < {5'h00, wl}) begin
              oe_n[l] = 1'b0;
              d[l]    = s_r.tbl[idx][5'h1f - pos[4:0]];
            end
          end
        end
      end
      s_nxt.a_oe_n = oe_n[0];
      s_nxt.a_out  = d[0];
      s_nxt.b_oe_n = oe_n[1];
      s_nxt.b_out  = d[1];
    end
  end

  // one register stage for all state
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r        <= '0;
      s_r.cnt    <= CNT_IDLE;
      s_r.a_oe_n <= 1'b1;
      s_r.b_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // lines come straight from flops
  assign lnk.line_a_out  = s_r.a_out;
  assign lnk.line_a_oe_n = s_r.a_oe_n;
  assign lnk.line_b_out  = s_r.b_out;
  assign lnk.line_b_oe_n = s_r.b_oe_n;
endmodule : meas_dev

// ==== hw/meas_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; both sides on the same clock.
*/
`timescale 1ns/1ps
module meas_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    empty;
  } fifo_st_t;

  fifo_st_t s_r, s_nxt;

  // push and pop, flags kept in flops
  always_comb begin
    logic push;
    logic pop;
    push  = in_valid & ~s_r.full;
    pop   = out_ready & ~s_r.empty;
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt   = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_nxt.full  = (s_nxt.cnt == (AW+1)'(DEPTH));
    s_nxt.empty = (s_nxt.cnt == '0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r       <= '0;
      s_r.empty <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready  = ~s_r.full;
  assign out_valid = ~s_r.empty;
  assign out_data  = s_r.mem[s_r.rp];
endmodule : meas_fifo

// ==== hw/meas_host.sv ====
/*
  Host end: makes bit clock and frame sync by dividing its own clock,
  drives the device configuration, captures both lines into slot words.
  Software reaches it over an Avalon-MM slave with waitrequest.
*/
`timescale 1ns/1ps
module meas_host
  import meas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  meas_link_if.host        lnk,
  input  wire logic [6:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest
);
  typedef struct packed {
    logic [2:0]       ctrl;
    logic [7:0]       fmt;
    logic [3:0]       txsel;
    logic [3:0]       txo;
    logic [1:0]       chsel;
    logic [2:0][9:0]  off;
    logic [3:0]       div;
    logic             bclk;
    logic             fs;
    logic [7:0]       bp;
    logic [1:0]       a_s;
    logic [1:0]       b_s;
    logic [31:0]      sh_a;
    logic [31:0]      sh_b;
    logic [7:0][31:0] rxa;
    logic [1:0][31:0] rxb;
    logic [15:0]      frames;
    logic             wait_r;
    logic [31:0]      rdata;
  } host_st_t;

  host_st_t s_r, s_nxt;

  always_comb begin
    logic [7:0]  last;
    logic [7:0]  bpn;
    logic [31:0] rd;
    logic [31:0] wa;
    logic [31:0] wb;
    logic        tdm;
    tdm   = s_r.ctrl[1];
    last  = tdm ? TDM_LAST : I2S_LAST;
    bpn   = (s_r.bp == last) ? 8'h00 : s_r.bp + 8'h01;
    wa    = {s_r.sh_a[30:0], s_r.a_s[1]};
    wb    = {s_r.sh_b[30:0], s_r.b_s[1]};
    s_nxt = s_r;
    s_nxt.a_s = {s_r.a_s[0], lnk.line_a};
    s_nxt.b_s = {s_r.b_s[0], lnk.line_b};

    // read mux; unmapped reads return zero
    rd = '0;
    case (address)
      REG_CTRL:  rd = {29'h0, s_r.ctrl};
      REG_FMT:   rd = {24'h0, s_r.fmt};
      REG_GRP:   rd = {26'h0, s_r.chsel, s_r.txsel};
      REG_OFF_V: rd = {22'h0, s_r.off[0]};
      REG_OFF_I: rd = {22'h0, s_r.off[1]};
      REG_OFF_A: rd = {22'h0, s_r.off[2]};
      REG_STAT:  rd = {16'h0, s_r.frames};
      default: begin
        if (address[6:5] == REG_RXA[6:5]) begin
          rd = s_r.rxa[address[4:2]];
        end else if (address[6:3] == REG_RXB[6:3]) begin
          rd = s_r.rxb[address[2]];
        end
      end
    endcase

    // one wait cycle, then the answer; writes land on the answer edge
    if ((read | write) && s_r.wait_r) begin
      s_nxt.wait_r = 1'b0;
      s_nxt.rdata  = rd;
    end else begin
      s_nxt.wait_r = 1'b1;
    end
    if (write && !s_r.wait_r) begin
      case (address)
        REG_CTRL:  s_nxt.ctrl   = writedata[2:0];
        REG_FMT:   s_nxt.fmt    = writedata[7:0];
        REG_GRP: begin
          s_nxt.txsel = writedata[3:0];
          s_nxt.chsel = writedata[5:4];
        end
        REG_OFF_V: s_nxt.off[0] = writedata[9:0];
        REG_OFF_I: s_nxt.off[1] = writedata[9:0];
        REG_OFF_A: s_nxt.off[2] = writedata[9:0];
        default: ;
      endcase
    end

    // off TDM, paired line placements always send group enables 0011 to the device
    if (!s_nxt.ctrl[1] && (s_nxt.fmt[FMT_LINE_LSB +: 4] == LINE_A12 ||
                           s_nxt.fmt[FMT_LINE_LSB +: 4] == LINE_A34)) begin
      s_nxt.txo = TXSEL_PAIR;
    end else begin
      s_nxt.txo = s_nxt.txsel;
    end

    // bit clock divider; stopped clock parks low and restarts a frame
    if (!s_r.ctrl[0]) begin
      s_nxt.div  = '0;
      s_nxt.bclk = 1'b0;
      s_nxt.fs   = tdm ? 1'b0 : 1'b1;
      s_nxt.bp   = last - 8'h01;
    end else if (s_r.div == 4'(BCLK_HALF - 1)) begin
      s_nxt.div  = '0;
      s_nxt.bclk = ~s_r.bclk;
      if (!s_r.bclk) begin
        // rising: sample the synchronised line level
        s_nxt.sh_a = wa;
        s_nxt.sh_b = wb;
        if (s_r.bp[4:0] == 5'h1f) begin
          s_nxt.rxa[s_r.bp[7:5]] = wa;
          if (s_r.bp[7:6] == 2'h0) begin
            s_nxt.rxb[s_r.bp[5]] = wb;
          end
        end
        if (s_r.bp == last) begin
          s_nxt.frames = s_r.frames + 16'h0001;
        end
      end else begin
        // falling: move to the next bit, sync one bit ahead of frame start
        s_nxt.bp = bpn;
        s_nxt.fs = tdm ? (bpn == last)
                       : (bpn >= I2S_HALF_LAST && bpn < I2S_LAST);
      end
    end else begin
      s_nxt.div = s_r.div + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r        <= '0;
      s_r.fmt    <= FMT_RST;
      s_r.txsel  <= TXSEL_RST;
      s_r.txo    <= TXSEL_RST;
      s_r.chsel  <= CHSEL_RST;
      s_r.off    <= {OFF_RST, OFF_RST, OFF_RST};
      s_r.bp     <= I2S_LAST - 8'h01;
      s_r.fs     <= 1'b1;
      s_r.a_s    <= 2'h3;
      s_r.b_s    <= 2'h3;
      s_r.wait_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.bclk       = s_r.bclk;
  assign lnk.frame_sync = s_r.fs;
  assign lnk.cfg        = {s_r.fmt, s_r.txo, s_r.chsel, s_r.off, s_r.ctrl[1], s_r.ctrl[2]};
  assign readdata       = s_r.rdata;
  assign waitrequest    = s_r.wait_r;
endmodule : meas_host

// ==== hw/meas_link_if.sv ====
/*
  Carrier between host end and device end: bit clock, frame sync, two
  shared output lines and the device configuration image.
  Assumes a pull-up on each line; a released line reads high.
*/
`timescale 1ns/1ps
interface meas_link_if;
  import meas_pkg::*;
  logic bclk;
  logic frame_sync;
  logic line_a_out;
  logic line_a_oe_n;
  logic line_b_out;
  logic line_b_oe_n;
  logic line_a;
  logic line_b;
  cfg_t cfg;

  // wire resolution, pull-up when nobody drives
  assign line_a = line_a_oe_n ? 1'b1 : line_a_out;
  assign line_b = line_b_oe_n ? 1'b1 : line_b_out;

  modport dev (input bclk, frame_sync, cfg,
               output line_a_out, line_a_oe_n, line_b_out, line_b_oe_n);
  modport host (output bclk, frame_sync, cfg, input line_a, line_b);
endinterface : meas_link_if

// ==== hw/meas_pkg.sv ====
/*
  Shared constants, configuration layout and helpers for the measurement
  serial output link: device end, host end and the carrier interface.
  Assumes one 125 MHz system clock on both ends.
*/
package meas_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int LINK_PERIOD_NS = 125;
  // longest half period rounds down
  localparam int BCLK_HALF      = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // frame geometry, position of the last bit clock in a frame
  localparam logic [7:0] TDM_LAST      = 8'hff;
  localparam logic [7:0] I2S_LAST      = 8'h3f;
  localparam logic [7:0] I2S_HALF_LAST = 8'h1f;
  localparam logic [10:0] CNT_IDLE     = 11'h7ff;
  localparam logic [10:0] TDM_SPAN     = 11'h080;

  // device format register, index and field positions
  localparam logic [7:0] FMT_REG_IDX = 8'h25;
  localparam int FMT_LINE_LSB = 4;
  localparam int FMT_WLA_LSB  = 2;
  localparam int FMT_WLB_LSB  = 0;
  localparam logic [7:0] FMT_RST     = 8'h1a;
  localparam logic [3:0] LINE_TDM_ALL = 4'h0;
  localparam logic [3:0] LINE_A12     = 4'h1;
  localparam logic [3:0] LINE_A34     = 4'h2;

  // group codes, also the tx_sel bit of each group
  localparam logic [1:0] GRP_VPRED  = 2'h0;
  localparam logic [1:0] GRP_ISENSE = 2'h1;
  localparam logic [1:0] GRP_AUX    = 2'h2;
  localparam logic [3:0] TXSEL_RST  = 4'h0;
  localparam logic [3:0] TXSEL_PAIR = 4'h3;
  localparam logic [1:0] CHSEL_RST  = 2'h0;
  localparam logic [9:0] OFF_RST    = 10'h3ff;

  // host register byte offsets
  localparam logic [6:0] REG_CTRL  = 7'h00;
  localparam logic [6:0] REG_FMT   = 7'h04;
  localparam logic [6:0] REG_GRP   = 7'h08;
  localparam logic [6:0] REG_OFF_V = 7'h0c;
  localparam logic [6:0] REG_OFF_I = 7'h10;
  localparam logic [6:0] REG_OFF_A = 7'h14;
  localparam logic [6:0] REG_STAT  = 7'h18;
  localparam logic [6:0] REG_RXA   = 7'h40;
  localparam logic [6:0] REG_RXB   = 7'h60;

  typedef struct packed {
    logic [7:0]      fmt;
    logic [3:0]      tx_sel;
    logic [1:0]      chsel;
    logic [2:0][9:0] off;
    logic            tdm;
    logic            fs48k;
  } cfg_t;

  // word length code to bit count
  function automatic logic [5:0] word_bits(input logic [1:0] code);
    case (code)
      2'h0:    return 6'h10;
      2'h1:    return 6'h14;
      2'h2:    return 6'h18;
      default: return 6'h20;
    endcase
  endfunction : word_bits
endpackage : meas_pkg

// ==== sim/amp_measurement_serial_out_bench.sv ====
/*
  bench: host end and device end joined by the carrier, driven over avalon and the sample stream.
  assumes design files and checker compiled first.
*/
`timescale 1ns/1ps
module amp_measurement_serial_out_bench
  import meas_pkg::*;
;
  localparam int I2S_WAIT = 4480;
  localparam int TDM_WAIT = 10752;
  logic        clk;
  logic        reset;
  logic [6:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        s_valid;
  logic        s_ready;
  logic [31:0] s_data;
  logic [1:0]  s_group;
  logic [1:0]  s_chan;
  int          err_total;
  int          n_checks;
  int          cycles;

  meas_link_if lnk ();
  meas_host meas_host_inst (.clk(clk), .reset(reset), .lnk(lnk), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  meas_dev meas_dev_inst (.clk(clk), .reset(reset), .lnk(lnk), .s_valid(s_valid), .s_ready(s_ready),
    .s_data(s_data), .s_group(s_group), .s_chan(s_chan));
  meas_link_chk meas_link_chk_inst (.clk(clk), .reset(reset), .bclk(lnk.bclk), .frame_sync(lnk.frame_sync),
    .line_a_out(lnk.line_a_out), .line_a_oe_n(lnk.line_a_oe_n), .line_b_out(lnk.line_b_out),
    .line_b_oe_n(lnk.line_b_oe_n), .cfg(lnk.cfg));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // a hang is cut short well past the 67k cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // sample as seen on the wire: word left-aligned, released tail reads high
  function automatic logic [31:0] ew(input int g, input int c, input int bits);
    logic [31:0] d;
    d = 32'h9c3a5e71 ^ {g[1:0], c[1:0], 24'h000000, g[1:0], c[1:0]};
    return d | (32'hffffffff >> bits);
  endfunction : ew

  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic [6:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    write     <= w;
    read      <= !w;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : av

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(a, 1'b1, d, q);
  endtask : wr

  task automatic rx(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] q;
    av(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask : rx

  task automatic setup(input logic [31:0] ctrl, input logic [31:0] fmt, input logic [31:0] grp, input int n);
    wr(REG_CTRL, ctrl);
    wr(REG_FMT, fmt);
    wr(REG_GRP, grp);
    repeat (n) @(posedge clk);
  endtask : setup

  task automatic push(input int g, input int c);
    @(posedge clk);
    s_valid <= 1'b1;
    s_group <= 2'(g);
    s_chan  <= 2'(c);
    s_data  <= ew(g, c, 32);
    do @(posedge clk); while (s_ready !== 1'b1);
    s_valid <= 1'b0;
  endtask : push

  // reset image and an unmapped slot
  task automatic t_regs();
    rx(REG_FMT, 32'h0000001a);
    rx(REG_GRP, 32'h00000000);
    rx(REG_OFF_V, 32'h000003ff);
    rx(7'h2c, 32'h00000000);
  endtask : t_regs

  // link parked, so nothing drains and the ninth sample must wait
  task automatic t_fill();
    for (int i = 0; i < 8; i++) push(i / 4, i % 4);
    @(posedge clk);
    chk({31'h0, s_ready}, 32'h0);
    wr(REG_OFF_V, 32'h0);
    wr(REG_OFF_I, 32'h0);
    wr(REG_CTRL, 32'h5);
    for (int i = 0; i < 4; i++) push(2, i);
  endtask : t_fill

  // i2s placement, select 1 then 2; 24-bit words on ch1/2, 32-bit on ch3/4
  task automatic t_i2s();
    setup(32'h5, 32'h1b, 32'h0, I2S_WAIT);
    rx(REG_RXA, ew(0, 0, 24));
    rx(REG_RXA + 7'h04, ew(0, 1, 24));
    rx(REG_RXB, ew(0, 2, 32));
    rx(REG_RXB + 7'h04, ew(0, 3, 32));
    setup(32'h5, 32'h2b, 32'h0, I2S_WAIT);
    rx(REG_RXA, ew(0, 2, 32));
    rx(REG_RXB, ew(0, 0, 24));
  endtask : t_i2s

  // group select; aux asked for with its enable, but the paired placement forces 0011
  task automatic t_sel();
    setup(32'h5, 32'h1b, 32'h10, I2S_WAIT);
    rx(REG_RXA, ew(1, 0, 24));
    rx(REG_RXB + 7'h04, ew(1, 3, 32));
    wr(REG_OFF_A, 32'h0);
    setup(32'h5, 32'h1b, 32'h24, I2S_WAIT);
    rx(REG_RXA, 32'hffffffff);
    setup(32'h5, 32'h1b, 32'h30, I2S_WAIT);
    rx(REG_RXA, 32'hffffffff);
    setup(32'h5, 32'h3b, 32'h0, I2S_WAIT);
    rx(REG_RXB, 32'hffffffff);
  endtask : t_sel

  // tdm: voltage at bit 0 in 20-bit words, current at bit 128 in 16-bit words
  task automatic t_tdm();
    logic b_idle;
    wr(REG_OFF_I, 32'h80);
    // aux parked past the frame end, the two other groups fill it
    wr(REG_OFF_A, 32'h3ff);
    setup(32'h7, 32'h04, 32'h7, TDM_WAIT);
    for (int i = 0; i < 8; i++) rx(REG_RXA + 7'(4 * i), i < 4 ? ew(0, i, 20) : ew(1, i - 4, 16));
    b_idle = 1'b1;
    repeat (3584) begin
      @(posedge clk);
      b_idle &= lnk.line_b;
    end
    chk({31'h0, b_idle}, 32'h1);
    setup(32'h3, 32'h04, 32'h1, TDM_WAIT);
    rx(REG_RXA, 32'hffffffff);
    setup(32'h7, 32'h04, 32'h0, TDM_WAIT);
    rx(REG_RXA + 7'h10, 32'hffffffff);
  endtask : t_tdm

  // frame counter: two reads whose sampled states lie one tdm frame (3584 clk) apart
  task automatic t_stat();
    logic [31:0] q0;
    logic [31:0] q1;
    av(REG_STAT, 1'b0, 32'h0, q0);
    repeat (3581) @(posedge clk);
    av(REG_STAT, 1'b0, 32'h0, q1);
    chk(q1 - q0, 32'h1);
  endtask : t_stat

  initial begin
    reset     = 1'b1;
    address   = 7'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
    s_valid   = 1'b0;
    s_data    = 32'h0;
    s_group   = 2'h0;
    s_chan    = 2'h0;
    err_total = 0;
    n_checks  = 0;
    cycles    = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_fill();
    t_i2s();
    t_sel();
    t_tdm();
    t_stat();
    complete_run();
  end
endmodule : amp_measurement_serial_out_bench

// ==== sim/meas_link_chk.sv ====
/*
  checker for the measurement link wires between host end and device end.
  assumes instantiation beside the carrier, one clk domain, sync reset.
*/
`timescale 1ns/1ps
module meas_link_chk
  import meas_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic bclk,
  input wire logic frame_sync,
  input wire logic line_a_out,
  input wire logic line_a_oe_n,
  input wire logic line_b_out,
  input wire logic line_b_oe_n,
  input wire cfg_t cfg
);
  logic [11:0] age_r;
  logic [11:0] age_nxt;
  cfg_t        cfg_r;
  logic        old;

  // config age; a tdm frame is 3584 clk, so a saturated count means no stale word left
  always_comb begin
    age_nxt = age_r;
    if (cfg != cfg_r)
      age_nxt = 12'h000;
    else if (age_r != 12'hfff)
      age_nxt = age_r + 12'h001;
  end

  always_ff @(posedge clk) begin
    cfg_r <= cfg;
    if (reset)
      age_r <= 12'h000;
    else
      age_r <= age_nxt;
  end

  assign old = (age_r == 12'hfff);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_release_at_reset: assert property ($fell(reset) |-> line_a_oe_n && line_b_oe_n)
    else $error("line driven after reset");
  chk_bclk_high: assert property (old && $rose(bclk) |-> bclk[*7])
    else $error("bit clock high half wrong");
  chk_bclk_low: assert property (old && $fell(bclk) |-> !bclk[*7])
    else $error("bit clock low half wrong");
  chk_sync_pulse: assert property (old && cfg.tdm && $rose(frame_sync) |-> frame_sync[*8] ##7 !frame_sync)
    else $error("tdm sync not one bit clock");
  chk_wire_steady: assert property (old && $rose(bclk) |->
    ##1 (!old || $stable({line_a_oe_n, line_a_out, line_b_oe_n, line_b_out}))[*6])
    else $error("line moved while bit clock high");
  chk_b_quiet_tdm: assert property (old && cfg.tdm && cfg.fmt[7:4] == LINE_TDM_ALL |-> line_b_oe_n)
    else $error("line b driven in tdm");
  chk_idle_no_grp: assert property (old && cfg.tx_sel == TXSEL_RST |-> line_a_oe_n && line_b_oe_n)
    else $error("line driven with no group");
  chk_vpred_48k: assert property (old && cfg.tdm && !cfg.fs48k && cfg.tx_sel == 4'h1 |-> line_a_oe_n)
    else $error("voltage driven off 48k");
  chk_bad_select: assert property (old && cfg.fmt[7:4] > LINE_A34 |-> line_a_oe_n && line_b_oe_n)
    else $error("line driven on unknown select");
  chk_chsel_none: assert property (old && !cfg.tdm && cfg.chsel == 2'h3 |-> line_a_oe_n && line_b_oe_n)
    else $error("line driven on group 3");

  cov_tdm_frame: cover property (cfg.tdm && $rose(frame_sync));
  cov_a_driven:  cover property (!cfg.tdm && !line_a_oe_n);
  cov_b_driven:  cover property (!line_b_oe_n);
endmodule : meas_link_chk
